// ==== rtl/dma_seq_map.svh ====
`ifndef DMA_SEQ_MAP_SVH
`define DMA_SEQ_MAP_SVH
// Register indices on the plain register port
`define OFS_CMD        5'h00
`define OFS_MASK       5'h01
`define OFS_REQ        5'h02
`define OFS_STATUS     5'h03
`define OFS_MODE0      5'h04
`define OFS_TEMP       5'h08
`define OFS_ADDR0      5'h10
`define OFS_CNT0       5'h14
// Command register fields
`define CMD_M2M        0
`define CMD_HOLD0      1
`define CMD_DISABLE    2
`define CMD_COMPRESS   3
`define CMD_ROTATE     4
`define CMD_ACK_HIGH   7
// Mode register fields
`define MODE_TYPE_LO   2
`define MODE_AUTO      4
`define MODE_DEC       5
`define MODE_SVC_LO    6
// Reset values
`define RST_CMD        8'h00
`define RST_MASK       4'hF
`define RST_MODE       8'h00
`endif

// ==== rtl/dma_seq_pkg.sv ====
package dma_seq_pkg;
  // Gray codes in listed order, one bit apart from each neighbour in the list
  typedef enum logic [4:0] {
    ST_I  = 5'h00, ST_0  = 5'h01, ST_1  = 5'h03, ST_2  = 5'h02,
    ST_3  = 5'h06, ST_W  = 5'h07, ST_4  = 5'h05, ST_11 = 5'h04,
    ST_12 = 5'h0C, ST_13 = 5'h0D, ST_14 = 5'h0F, ST_21 = 5'h0E,
    ST_22 = 5'h0A, ST_23 = 5'h0B, ST_24 = 5'h09, ST_C  = 5'h08
  } state_t;
  typedef enum logic [1:0] {
    SVC_DEMAND = 2'h0, SVC_SINGLE = 2'h1, SVC_BLOCK = 2'h2, SVC_CASCADE = 2'h3
  } svc_t;
  typedef enum logic [1:0] {
    XF_VERIFY = 2'h0, XF_WRITE = 2'h1, XF_READ = 2'h2, XF_ILLEGAL = 2'h3
  } xfer_t;
endpackage : dma_seq_pkg

// ==== rtl/dma_active_cycle_sequencer.sv ====
`timescale 1ns/100ps
`include "dma_seq_map.svh"
// Overview of operation
// - Idle with a pending unmasked or software request raises hold request.
// - Single mode: one transfer per service, then hold drops and is re-requested.
// - Each transfer steps address and count; underflow sets status, pulses EOP, masks.
// - Block mode runs until count underflow or external EOP.
// - Demand mode also stops when the request drops; current registers keep progress.
// - Autoinitialize on an EOP event or a channel 0 move underflow, never on a demand request drop.
// - Cascade passes request to acknowledge, drives only hold, ignores external EOP.
// - Acknowledges reset active low, held high; software may make them active high.
// - Write type: memory write with I/O read; read type: memory read with I/O write.
// - Verify steps and counts like a transfer but keeps strobes quiet, ignores ready.
// - Autoinitialize reloads current from base after EOP and leaves mask clear.
// - Command bit 0 pairs channels 0 and 1 for memory moves started on channel 0.
// - Memory move reads channel 0 address into temp, writes at channel 1 address.
// - Channel 1 underflow ends the move with EOP, status, and mask unless autoinit.
// - Channel 0 underflow in a move only autoinitializes channel 0 when selected.
// - Command bit 1 holds channel 0 source address fixed during a move.
// - External EOP ends a move after S24; autoinitializes channel 1 only.
// - Fixed priority: channel 0 highest; a granted service is never interrupted.
// - Rotating priority: served channel becomes lowest when the bus returns.
// - Compressed timing skips S3, EOP in S2, keeps S1 for upper address changes.
// - Upper address goes out on data lines in S1 with strobe, at service start, after autoinitialize, and when it changes.
// - After hold request the sequencer waits in S0 for hold acknowledge.
// - Ready low inserts waits after S3, or after S2 when compressed.
module dma_active_cycle_sequencer
  import dma_seq_pkg::*;
#(
  parameter int CH_N = 4
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [4:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic [3:0]  channel_request_in_i,
  input  wire logic        hold_acknowledge_i,
  input  wire logic        ready_i,
  input  wire logic        end_of_process_i,
  input  wire logic [7:0]  data_i,
  output logic [7:0]       data_o,
  output logic             data_oe_o,
  output logic [7:0]       address_o,
  output logic             hold_request_o,
  output logic [3:0]       channel_acknowledge_out_o,
  output logic             end_of_process_o,
  output logic             address_enable_o,
  output logic             upper_address_strobe_o,
  output logic             memory_read_strobe_o,
  output logic             memory_write_strobe_o,
  output logic             io_read_strobe_o,
  output logic             io_write_strobe_o
);
  if (CH_N != 4) begin : g_chk
    $error("dma_active_cycle_sequencer serves exactly four channels");
  end

  logic [7:0]  cmd;
  logic [3:0]  mask;
  logic [3:0]  sw_req;
  logic [3:0]  tc_stat;
  logic [7:0]  temp;
  logic [7:0]  mode     [4];
  logic [15:0] cur_addr [4];
  logic [15:0] cur_cnt  [4];
  logic [15:0] base_addr[4];
  logic [15:0] base_cnt [4];
  state_t      state;
  state_t      next_state;
  logic [1:0]  gch;
  logic [1:0]  top;
  logic        need_up;
  logic        ext_seen;

  // Pin inputs: three stages, a change counts once stages two and three agree
  logic [14:0] pin_s1, pin_s2, pin_s3, pin_f;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1 <= 15'h0000;
      pin_s2 <= 15'h0000;
      pin_s3 <= 15'h0000;
      pin_f  <= 15'h0000;
    end else begin
      pin_s1 <= {data_i, end_of_process_i, ready_i, hold_acknowledge_i, channel_request_in_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f  <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));
    end
  end
  wire [3:0] channel_request_in    = pin_f[3:0];
  wire       hold_acknowledge    = pin_f[4];
  wire       rdy     = pin_f[5];
  wire       eop_in  = pin_f[6];
  wire [7:0] din     = pin_f[14:7];

  // Channel attributes of the granted channel
  wire        m2m     = cmd[`CMD_M2M];
  wire        comp    = cmd[`CMD_COMPRESS] & ~m2m;
  wire [7:0]  gmode   = mode[gch];
  wire [1:0]  gsvc    = gmode[`MODE_SVC_LO+1:`MODE_SVC_LO];
  wire [1:0]  gtype   = gmode[`MODE_TYPE_LO+1:`MODE_TYPE_LO];
  wire        verify  = (gtype == XF_VERIFY);
  wire        rdy_ok  = rdy | verify;

  // Requests: masked hardware plus software; channel 1 cannot start a move
  wire [3:0] pend = ((channel_request_in & ~mask) | sw_req) & ~(m2m ? 4'h2 : 4'h0);
  wire       any_pend = |pend;
  wire [1:0] top_eff  = cmd[`CMD_ROTATE] ? top : 2'h0;
  logic [1:0] win;
  logic       found;
  logic [1:0] idx;
  // Priority search starting at the highest ranked channel
  always_comb begin
    win   = 2'h0;
    found = 1'b0;
    idx   = 2'h0;
    for (int i = 0; i < 4; i++) begin
      idx = top_eff + 2'(i);
      if (!found && pend[idx]) begin
        win   = idx;
        found = 1'b1;
      end
    end
  end

  // Transfer completion: S4 for normal, S14 and S24 for memory moves
  wire        upd     = (state == ST_4) | (state == ST_14) | (state == ST_24);
  wire [1:0]  uch     = (state == ST_14) ? 2'h0 : (state == ST_24) ? 2'h1 : gch;
  wire        uauto   = mode[uch][`MODE_AUTO];
  wire        udec    = mode[uch][`MODE_DEC];
  wire        uhold   = (state == ST_14) & cmd[`CMD_HOLD0];
  wire [15:0] ua      = cur_addr[uch];
  wire [15:0] na      = uhold ? ua : (udec ? ua - 16'h0001 : ua + 16'h0001);
  wire        uzero   = (cur_cnt[uch] == 16'h0000);
  wire        uext    = ext_seen & (state != ST_14) & (gsvc != SVC_CASCADE);
  wire        eop_evt = upd & (state != ST_14) & (uzero | uext);
  wire        restore = upd & uauto & ((state == ST_14) ? uzero : eop_evt);
  wire        set_msk = eop_evt & ~uauto;
  wire        carry   = (na[15:8] != ua[15:8]);
  // Service end: EOP, single mode each time, demand when request drops
  wire        end_svc = eop_evt | ((state == ST_4) & ((gsvc == SVC_SINGLE)
                        | ((gsvc == SVC_DEMAND) & ~channel_request_in[gch])));

  // Sequencer
  always_comb begin
    next_state = state;
    case (state)
      // A fresh grant is awaited: the old acknowledge must have dropped first
      ST_I:  if (any_pend && !cmd[`CMD_DISABLE] && !hold_acknowledge) next_state = ST_0;
      ST_0:  begin
        if (hold_acknowledge) begin
          if (!any_pend) next_state = ST_I;
          else if (mode[win][`MODE_SVC_LO+1:`MODE_SVC_LO] == SVC_CASCADE) next_state = ST_C;
          else if (m2m && win == 2'h0) next_state = ST_11;
          else next_state = ST_1;
        end
      end
      ST_C:  if (!channel_request_in[gch] || mask[gch]) next_state = ST_I;
      ST_1:  next_state = ST_2;
      ST_2:  next_state = comp ? (rdy_ok ? ST_4 : ST_W) : ST_3;
      ST_3:  next_state = rdy_ok ? ST_4 : ST_W;
      ST_W:  if (rdy_ok) next_state = ST_4;
      ST_4:  next_state = end_svc ? ST_I : ((need_up || carry) ? ST_1 : ST_2);
      ST_11: next_state = ST_12;
      ST_12: next_state = ST_13;
      ST_13: if (rdy) next_state = ST_14;
      ST_14: next_state = ST_21;
      ST_21: next_state = ST_22;
      ST_22: next_state = ST_23;
      ST_23: if (rdy) next_state = ST_24;
      ST_24: next_state = eop_evt ? ST_I : ST_11;
      default: next_state = ST_I;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) state <= ST_I;
    else       state <= next_state;
  end

  // Grant is latched only at hold acknowledge, so nothing preempts a service
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gch <= 2'h0;
      top <= 2'h0;
    end else begin
      if (state == ST_0 && hold_acknowledge) gch <= win;
      if (state != ST_I && next_state == ST_I) top <= gch + 2'h1;
    end
  end

  // Upper address reload flag and external EOP capture (set wins)
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      need_up  <= 1'b0;
      ext_seen <= 1'b0;
    end else begin
      if (state == ST_0) need_up <= 1'b1;
      else if (state == ST_1) need_up <= 1'b0;
      else if (upd && restore) need_up <= 1'b1;
      ext_seen <= (eop_in & (state != ST_I)) | (ext_seen & ~(upd & (state != ST_14))
                  & (state != ST_I));
    end
  end

  // Register port decode
  wire       wr_ch   = reg_wr_i & (state == ST_I);
  wire [1:0] rch     = reg_addr_i[1:0];
  wire       hit_mode = (reg_addr_i[4:2] == 3'h1);
  wire       hit_addr = (reg_addr_i[4:2] == 3'h4);
  wire       hit_cnt  = (reg_addr_i[4:2] == 3'h5);
  wire       stat_rd  = reg_rd_i & (reg_addr_i == `OFS_STATUS);

  // Channel registers: hardware steps them; programming happens while idle
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int c = 0; c < 4; c++) begin
        mode[c]      <= `RST_MODE;
        cur_addr[c]  <= 16'h0000;
        cur_cnt[c]   <= 16'h0000;
        base_addr[c] <= 16'h0000;
        base_cnt[c]  <= 16'h0000;
      end
    end else begin
      if (upd) begin
        cur_addr[uch] <= restore ? base_addr[uch] : na;
        cur_cnt[uch]  <= restore ? base_cnt[uch] : cur_cnt[uch] - 16'h0001;
      end
      if (wr_ch && hit_mode) mode[rch] <= reg_wdata_i[7:0];
      if (wr_ch && hit_addr) begin
        cur_addr[rch]  <= reg_wdata_i;
        base_addr[rch] <= reg_wdata_i;
      end
      if (wr_ch && hit_cnt) begin
        cur_cnt[rch]  <= reg_wdata_i;
        base_cnt[rch] <= reg_wdata_i;
      end
    end
  end

  // Global registers; hardware set wins over a status read clear
  wire [3:0] ev_bit = eop_evt ? (4'h1 << uch) : 4'h0;
  // A move is requested on channel 0 but ends on channel 1; clear both
  wire [3:0] req_clr = ev_bit | ((eop_evt && state == ST_24) ? 4'h1 : 4'h0);
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd     <= `RST_CMD;
      mask    <= `RST_MASK;
      sw_req  <= 4'h0;
      tc_stat <= 4'h0;
      temp    <= 8'h00;
    end else begin
      if (wr_ch && reg_addr_i == `OFS_CMD) cmd <= reg_wdata_i[7:0];
      if (wr_ch && reg_addr_i == `OFS_MASK) mask <= reg_wdata_i[3:0];
      else if (set_msk) mask <= mask | ev_bit;
      if (wr_ch && reg_addr_i == `OFS_REQ) sw_req <= reg_wdata_i[3:0];
      else sw_req <= sw_req & ~req_clr;
      tc_stat <= (tc_stat & ~(stat_rd ? 4'hF : 4'h0)) | ev_bit;
      if (state == ST_14) temp <= din;
    end
  end

  // Read data stands in the cycle after the read strobe only
  logic [15:0] rd_val;
  always_comb begin
    rd_val = 16'h0000;
    case (reg_addr_i)
      `OFS_CMD:    rd_val = {8'h00, cmd};
      `OFS_MASK:   rd_val = {12'h000, mask};
      `OFS_REQ:    rd_val = {12'h000, sw_req};
      `OFS_STATUS: rd_val = {8'h00, channel_request_in, tc_stat};
      `OFS_TEMP:   rd_val = {8'h00, temp};
      default: begin
        if (hit_mode) rd_val = {8'h00, mode[rch][7:2], 2'h3};
        else if (hit_addr) rd_val = cur_addr[rch];
        else if (hit_cnt) rd_val = cur_cnt[rch];
        else rd_val = 16'h0000;
      end
    endcase
  end

  // Output decode from the present state; registered, so pins trail by one cycle
  wire in_xfer  = (state == ST_1) | (state == ST_2) | (state == ST_3)
                | (state == ST_W) | (state == ST_4);
  wire rd_half  = (state == ST_11) | (state == ST_12) | (state == ST_13) | (state == ST_14);
  wire wr_half  = (state == ST_21) | (state == ST_22) | (state == ST_23) | (state == ST_24);
  wire up_st    = (state == ST_1) | (state == ST_11) | (state == ST_21);
  wire rd_side  = (state == ST_3) | (state == ST_W) | (state == ST_4);
  wire wr_side  = (state == ST_W) | (state == ST_4);
  wire t_rd     = in_xfer & (gtype == XF_READ);
  wire t_wr     = in_xfer & (gtype == XF_WRITE);
  wire [3:0] ack_act = (in_xfer | (state == ST_C)) ? (4'h1 << gch) : 4'h0;
  wire [3:0] ack_pin = cmd[`CMD_ACK_HIGH] ? ack_act : ~ack_act;
  wire eop_pls  = comp ? ((state == ST_2) & (cur_cnt[gch] == 16'h0000))
                       : (eop_evt & (uzero | (state == ST_24)));
  wire [7:0] up_byte = (state == ST_11) ? cur_addr[0][15:8]
                     : (state == ST_21) ? cur_addr[1][15:8] : cur_addr[gch][15:8];
  wire [7:0] lo_byte = rd_half ? cur_addr[0][7:0]
                     : wr_half ? cur_addr[1][7:0] : cur_addr[gch][7:0];

  // Output flip-flops
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o               <= 16'h0000;
      data_o                    <= 8'h00;
      data_oe_o                 <= 1'b0;
      address_o                 <= 8'h00;
      hold_request_o            <= 1'b0;
      channel_acknowledge_out_o <= 4'hF;
      end_of_process_o          <= 1'b0;
      address_enable_o          <= 1'b0;
      upper_address_strobe_o    <= 1'b0;
      memory_read_strobe_o      <= 1'b0;
      memory_write_strobe_o     <= 1'b0;
      io_read_strobe_o          <= 1'b0;
      io_write_strobe_o         <= 1'b0;
    end else begin
      reg_rdata_o               <= reg_rd_i ? rd_val : 16'h0000;
      data_o                    <= up_st ? up_byte : temp;
      data_oe_o                 <= up_st | wr_half;
      address_o                 <= lo_byte;
      hold_request_o            <= (state != ST_I);
      channel_acknowledge_out_o <= ack_pin;
      end_of_process_o          <= eop_pls;
      address_enable_o          <= in_xfer | rd_half | wr_half;
      upper_address_strobe_o    <= up_st;
      memory_read_strobe_o      <= (t_rd & rd_side) | (state == ST_13) | (state == ST_14);
      memory_write_strobe_o     <= (t_wr & wr_side) | (state == ST_23) | (state == ST_24);
      io_read_strobe_o          <= t_wr & rd_side;
      io_write_strobe_o         <= t_rd & wr_side;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_idle_req;
    state == ST_I && any_pend && !cmd[`CMD_DISABLE] && !hold_acknowledge;
  endsequence
  a_idle_to_hold: assert property (s_idle_req |=> state == ST_0 ##1 hold_request_o)
    else $error("pending request did not raise hold");
  a_wait_for_ack: assert property (state == ST_0 && !hold_acknowledge |=> state == ST_0)
    else $error("left S0 without hold acknowledge");
  a_single_release: assert property (state == ST_4 && gsvc == SVC_SINGLE
    |=> state == ST_I ##1 !hold_request_o)
    else $error("single transfer did not release the bus");
  a_tc_status: assert property (eop_evt |=> tc_stat[$past(uch)])
    else $error("status bit not set at end of process");
  a_mask_on_end: assert property (set_msk |=> mask[$past(uch)])
    else $error("mask not set at end of process");
  a_autoinit_load: assert property (restore
    |=> cur_cnt[$past(uch)] == base_cnt[$past(uch)] && !$rose(mask[$past(uch)]))
    else $error("autoinitialize did not reload the count");
  a_verify_quiet: assert property (in_xfer && verify |=> !memory_read_strobe_o
    && !memory_write_strobe_o && !io_read_strobe_o && !io_write_strobe_o)
    else $error("strobe active during verify");
  a_m2m_no_ack: assert property (rd_half || wr_half |=> address_enable_o
    && channel_acknowledge_out_o == (cmd[`CMD_ACK_HIGH] ? 4'h0 : 4'hF))
    else $error("acknowledge active during memory move");
  a_wait_insert: assert property (state == ST_3 && !rdy && !verify |=> state == ST_W)
    else $error("no wait state with ready low");
  a_comp_skip: assert property (state == ST_2 && comp |=> state != ST_3)
    else $error("compressed timing entered S3");
  a_hold_source: assert property (state == ST_14 && cmd[`CMD_HOLD0]
    |=> $stable(cur_addr[0]))
    else $error("held source address moved");
  a_grant_fixed: assert property (in_xfer && $past(in_xfer) |-> $stable(gch))
    else $error("grant changed during a service");
endmodule : dma_active_cycle_sequencer

// ==== testbench/dma_far_side_model.sv ====
`timescale 1ns/100ps
module dma_far_side_model (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       slow_i,
  input  wire logic [3:0] want_i,
  input  wire logic       hold_request_i,
  input  wire logic [3:0] channel_acknowledge_out_i,
  output logic            hold_acknowledge_o,
  output logic            ready_o,
  output logic [3:0]      channel_request_o,
  output logic [7:0]      data_o
);
  logic [2:0] grant_wait;
  logic [1:0] phase;

  // Host: grants after a short or long pause, lets go as soon as hold drops
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      grant_wait         <= 3'h0;
      hold_acknowledge_o <= 1'b0;
    end else if (!hold_request_i) begin
      grant_wait         <= 3'h0;
      hold_acknowledge_o <= 1'b0;
    end else if (grant_wait == (slow_i ? 3'h5 : 3'h1)) begin
      hold_acknowledge_o <= 1'b1;
    end else begin
      grant_wait <= grant_wait + 3'h1;
    end
  end

  // Peripherals and memory; acknowledges are taken as active high
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase             <= 2'h0;
      ready_o           <= 1'b1;
      channel_request_o <= 4'h0;
      data_o            <= 8'h00;
    end else begin
      phase             <= phase + 2'h1;
      ready_o           <= !slow_i || phase[1];
      channel_request_o <= (channel_request_o | want_i) & ~channel_acknowledge_out_i;
      // Memory byte only while the bus is ours with no peripheral picked; else churn
      data_o            <= (hold_acknowledge_o && channel_acknowledge_out_i == 4'h0) ?
                           8'h5A : ~data_o;
    end
  end
endmodule : dma_far_side_model

// ==== testbench/dma_active_cycle_sequencer_tb_top.sv ====
`timescale 1ns/100ps
module dma_active_cycle_sequencer_tb_top;
  logic        ref_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic [4:0]  reg_addr  = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        slow      = 1'b0;
  logic        mm        = 1'b0;
  logic        ext_eop   = 1'b0;
  logic        strobe_q  = 1'b0;
  logic [3:0]  want      = 4'h0;
  logic [15:0] reg_rdata;
  logic [3:0]  req, ack;
  logic [7:0]  mem_data;
  logic        hold_ack, ready, hold_req, eop, address_enable, memory_read_strobe, memory_write_strobe, io_read_strobe, io_write_strobe;
  int          n_mismatch = 0;
  int          n_tests    = 0;
  int          cycles     = 0;
  int          n_eop      = 0;
  int          n_xfer     = 0;
  int          n_bad      = 0;
  int          x0, e0;

  always #2 ref_clk_i = ~ref_clk_i;

  dma_active_cycle_sequencer dma_active_cycle_sequencer_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .channel_request_in_i(req), .hold_acknowledge_i(hold_ack), .ready_i(ready),
    .end_of_process_i(ext_eop), .data_i(mem_data), .data_o(), .data_oe_o(), .address_o(),
    .hold_request_o(hold_req), .channel_acknowledge_out_o(ack), .end_of_process_o(eop),
    .address_enable_o(address_enable), .upper_address_strobe_o(), .memory_read_strobe_o(memory_read_strobe),
    .memory_write_strobe_o(memory_write_strobe), .io_read_strobe_o(io_read_strobe), .io_write_strobe_o(io_write_strobe));

  dma_far_side_model dma_far_side_model_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .slow_i(slow), .want_i(want),
    .hold_request_i(hold_req), .channel_acknowledge_out_i(ack),
    .hold_acknowledge_o(hold_ack), .ready_o(ready), .channel_request_o(req),
    .data_o(mem_data));

  // Watcher: transfer starts, end pulses, strobes outside their proper company
  always @(posedge ref_clk_i) begin
    cycles   <= cycles + 1;
    strobe_q <= memory_read_strobe | memory_write_strobe;
    if ((memory_read_strobe | memory_write_strobe) && !strobe_q) n_xfer <= n_xfer + 1;
    if (eop) n_eop <= n_eop + 1;
    if (address_enable && !hold_ack) n_bad <= n_bad + 1;
    // Read strobe may lead its partner by S3; a write strobe never stands alone
    if (ack != 4'h0 && ((memory_write_strobe && !io_read_strobe) || (io_write_strobe && !memory_read_strobe))) n_bad <= n_bad + 1;
    if (mm && address_enable && ack !== 4'h0) n_bad <= n_bad + 1;
    if (cycles == 30000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr    <= 1'b0;
  endtask : reg_write

  // Read data stands only in the cycle after the read strobe
  task automatic reg_check(input string name, input logic [4:0] a, input logic [15:0] exp);
    @(posedge ref_clk_i);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd   <= 1'b0;
    #1;
    chk(name, exp, reg_rdata);
  endtask : reg_check

  task automatic setup(input logic [1:0] ch, input logic [7:0] mode,
                       input logic [15:0] addr, input logic [15:0] cnt);
    reg_write({3'h1, ch}, {8'h00, mode});
    reg_write({3'h4, ch}, addr);
    reg_write({3'h5, ch}, cnt);
    x0 = n_xfer;
    e0 = n_eop;
  endtask : setup

  // Raise the chosen requests, then wait for the bus to be handed back
  task automatic run(input logic [3:0] w, input logic x);
    int i;
    want <= w;
    @(posedge ref_clk_i);
    want <= 4'h0;
    for (i = 0; i < 200 && hold_req !== 1'b1; i++) begin
      @(negedge ref_clk_i);
    end
    @(posedge ref_clk_i);
    ext_eop <= x;
    for (i = 0; i < 4000 && hold_req !== 1'b0; i++) begin
      @(negedge ref_clk_i);
    end
    chk("hold released", 16'h0000, {15'h0000, hold_req});
    repeat (4) @(posedge ref_clk_i);
    ext_eop <= 1'b0;
  endtask : run

  task automatic outcome(input int xf, input int ep, input logic [15:0] st,
                         input logic [15:0] mk);
    chk("transfers", 16'(xf), 16'(n_xfer - x0));
    chk("end pulses", 16'(ep), 16'(n_eop - e0));
    reg_check("status", 5'h03, st);
    reg_check("mask", 5'h01, mk);
  endtask : outcome

  task automatic check_reset();
    @(negedge ref_clk_i);
    chk("ack idle", 16'h000F, {12'h000, ack});
    reg_check("mask", 5'h01, 16'h000F);
    reg_check("command", 5'h00, 16'h0000);
    reg_check("unmapped", 5'h1F, 16'h0000);
  endtask : check_reset

  // Single read, one byte, slow host, upper address carry
  task automatic single_read();
    reg_write(5'h00, 16'h0080);
    setup(2'd2, 8'h48, 16'h12FF, 16'h0000);
    reg_write(5'h01, 16'h000B);
    slow <= 1'b1;
    run(4'h4, 1'b0);
    outcome(1, 1, 16'h0004, 16'h000F);
    reg_check("address", 5'h12, 16'h1300);
    reg_check("count", 5'h16, 16'hFFFF);
  endtask : single_read

  // Block write, decrement, autoinit, compressed timing
  task automatic block_auto();
    reg_write(5'h00, 16'h0088);
    setup(2'd0, 8'hB4, 16'h0100, 16'h0002);
    reg_write(5'h01, 16'h000E);
    slow <= 1'b0;
    run(4'h1, 1'b0);
    outcome(3, 1, 16'h0001, 16'h000E);
    reg_check("address", 5'h10, 16'h0100);
    reg_check("count", 5'h14, 16'h0002);
  endtask : block_auto

  // Verify: counts and steps, strobes quiet, ready ignored
  task automatic verify_block();
    reg_write(5'h00, 16'h0080);
    setup(2'd3, 8'h80, 16'h0200, 16'h0001);
    reg_write(5'h01, 16'h0007);
    slow <= 1'b1;
    run(4'h8, 1'b0);
    outcome(0, 1, 16'h0008, 16'h000F);
    reg_check("address", 5'h13, 16'h0202);
  endtask : verify_block

  // Demand read cut by an external end of process at its first transfer
  task automatic ext_stop();
    reg_write(5'h00, 16'h0080);
    setup(2'd1, 8'h08, 16'h0500, 16'h0005);
    reg_write(5'h01, 16'h000D);
    slow <= 1'b0;
    run(4'h2, 1'b1);
    outcome(1, 0, 16'h0002, 16'h000F);
    reg_check("address", 5'h11, 16'h0501);
    reg_check("count", 5'h15, 16'h0004);
  endtask : ext_stop

  // Memory move, two bytes, software request on channel 0
  task automatic memory_move();
    reg_write(5'h00, 16'h0081);
    setup(2'd1, 8'h84, 16'h0400, 16'h0001);
    reg_write(5'h10, 16'h0300);
    reg_write(5'h14, 16'h0001);
    reg_write(5'h04, 16'h0088);
    reg_write(5'h01, 16'h000C);
    slow <= 1'b0;
    mm   <= 1'b1;
    reg_write(5'h02, 16'h0001);
    run(4'h0, 1'b0);
    mm <= 1'b0;
    outcome(4, 1, 16'h0002, 16'h000E);
    reg_check("temp", 5'h08, 16'h005A);
    reg_check("source", 5'h10, 16'h0302);
    reg_check("target", 5'h11, 16'h0402);
    reg_check("source count", 5'h14, 16'hFFFF);
  endtask : memory_move

  task automatic summarize();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    check_reset();
    single_read();
    block_auto();
    verify_block();
    ext_stop();
    memory_move();
    chk("bus faults", 16'h0000, 16'(n_bad));
    summarize();
  end
endmodule : dma_active_cycle_sequencer_tb_top
